/* File: hdl/dtc_pkg.sv */
// Purpose: shared constants and types for the dual timer/counter block
// Assumes: 32-bit apb data, byte-wide timer registers in the low bits
// Notes:   all register offsets are byte addresses of aligned words
package dtc_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_TL0  = 8'h08;
    localparam logic [7:0] ADDR_TH0  = 8'h0C;
    localparam logic [7:0] ADDR_TL1  = 8'h10;
    localparam logic [7:0] ADDR_TH1  = 8'h14;
    localparam logic [7:0] ADDR_CLK  = 8'h18;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int         CTRL_RUN0_BIT = 4;
    localparam int         CTRL_OVF0_BIT = 5;
    localparam int         CTRL_RUN1_BIT = 6;
    localparam int         CTRL_OVF1_BIT = 7;
    localparam int         CLK_FAST_BIT  = 0;
    localparam logic [7:0] RST_MODE      = 8'h00;
    localparam logic [1:0] RST_RUN       = 2'b00;
    localparam logic [1:0] RST_FLAG      = 2'b00;
    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic [4:0] PRESC_MAX     = 5'h1F;
    localparam logic [7:0] BYTE_MAX      = 8'hFF;

    // ------------------------------------------------------------------
    // machine cycle timing, in oscillator periods
    // ------------------------------------------------------------------
    localparam int         OSC_PER_CYCLE      = 12;
    localparam int         OSC_PER_CYCLE_FAST = 6;
    localparam logic [3:0] DIV_SLOW_LAST      = 4'(OSC_PER_CYCLE - 1);
    localparam logic [3:0] DIV_FAST_LAST      = 4'(OSC_PER_CYCLE_FAST - 1);

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_13     = 2'b00,
        MODE_16     = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT  = 2'b11
    } dtc_mode_type;

    typedef struct packed {
        logic         gate;
        logic         cnt_sel;
        dtc_mode_type mode;
    } dtc_tcfg_type;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } dtc_count_type;

    typedef struct packed {
        logic          ovf;
        dtc_count_type cnt;
    } dtc_step_type;

endpackage

/* File: hdl/dtc_cycle_gen.sv */
// Purpose: machine cycle tick from the oscillator clock
// Assumes: ref_clk is the oscillator, divided by twelve or six
// Notes:   tick is a one-clock pulse, registered
`timescale 1ns/100ps
module dtc_cycle_gen
    import dtc_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic fast_sel,
    output logic      tick
);

    logic [3:0] div_q;
    logic [3:0] last;

    assign last = fast_sel ? DIV_FAST_LAST : DIV_SLOW_LAST;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            div_q <= 4'h0;
            tick  <= 1'b0;
        end else if (ce) begin
            // switching divide ratio mid-cycle may stretch one cycle
            if (div_q >= last) begin
                div_q <= 4'h0;
                tick  <= 1'b1;
            end else begin
                div_q <= div_q + 4'h1;
                tick  <= 1'b0;
            end
        end
    end

endmodule

/* File: hdl/dtc_edge_sense.sv */
// Purpose: falling edge detector on a count pin, sampled per machine cycle
// Assumes: pin is synchronous to ref_clk
// Notes:   fall pulses for one clock after the tick that saw high then low
`timescale 1ns/100ps
module dtc_edge_sense (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic tick,
    input  wire logic pin,
    output logic      fall
);

    logic samp_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            samp_q <= 1'b0;
            fall   <= 1'b0;
        end else if (ce) begin
            fall <= tick & samp_q & ~pin;
            if (tick) begin
                samp_q <= pin;
            end
        end
    end

endmodule

/* File: hdl/dtc_top.sv */
// Purpose: two 16-bit up timer/counters with apb register access
// Assumes: count and gate pins synchronous to ref_clk; instr_done marks
//          the end of each processor instruction
// Notes:   mode and run writes wait in shadow registers until instr_done
`timescale 1ns/100ps
module dtc_top
    import dtc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        count_input_0,
    input  wire logic        count_input_1,
    input  wire logic        ext_irq_pin_0,
    input  wire logic        ext_irq_pin_1,
    input  wire logic        instr_done,
    input  wire logic [1:0]  vec_ack,
    output logic             ovf_flag_0,
    output logic             ovf_flag_1,
    output logic             baud_pulse
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    dtc_tcfg_type [1:0] cfg_q;
    dtc_tcfg_type [1:0] cfg_pend_q;
    logic [1:0]         run_q;
    logic [1:0]         run_pend_q;
    logic               fast_q;
    dtc_count_type      cnt_q [2];
    dtc_count_type      cnt_d [2];
    dtc_step_type       step  [2];
    logic [1:0]         inc;
    logic [1:0]         ovf_evt;
    logic [1:0]         flag_set;
    logic [1:0]         flag_clr;
    logic [1:0]         wr_lo;
    logic [1:0]         wr_hi;
    logic [1:0]         edge_fall;
    logic [1:0]         count_pins;
    logic [1:0]         gate_pins;
    logic               tick;
    logic               split0;
    logic               hi_inc;
    logic               hi_ovf;
    logic               acc_first;
    logic               wr_en;
    logic               mapped;
    logic [7:0]         rd_byte;

    assign count_pins = {count_input_1, count_input_0};
    // pins are only read here, never loaded or altered
    assign gate_pins  = {ext_irq_pin_1, ext_irq_pin_0};
    assign split0     = (cfg_q[0].mode == MODE_SPLIT);

    // ------------------------------------------------------------------
    // step of one count register by one increment
    // ------------------------------------------------------------------
    function automatic dtc_step_type step_count(dtc_mode_type m, dtc_count_type c);
        dtc_step_type r;
        r.cnt = c;
        r.ovf = 1'b0;
        unique case (m)
            MODE_13: begin
                // upper three low bits are left alone and carry no meaning
                r.cnt.low[4:0] = c.low[4:0] + 5'h01;
                if (c.low[4:0] == PRESC_MAX) begin
                    r.cnt.high = c.high + 8'h01;
                    r.ovf      = (c.high == BYTE_MAX);
                end
            end
            MODE_16: begin
                {r.ovf, r.cnt} = {1'b0, c} + 17'h0_0001;
            end
            MODE_RELOAD: begin
                if (c.low == BYTE_MAX) begin
                    r.cnt.low = c.high;
                    r.ovf     = 1'b1;
                end else begin
                    r.cnt.low = c.low + 8'h01;
                end
            end
            MODE_SPLIT: begin
                {r.ovf, r.cnt.low} = {1'b0, c.low} + 9'h001;
            end
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // machine cycle and count pin sampling
    // ------------------------------------------------------------------
    dtc_cycle_gen u_cycle (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .fast_sel (fast_q),
        .tick     (tick)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tmr
            logic src;
            logic run_eff;
            logic allowed;

            // a level held under one machine cycle may be missed entirely
            dtc_edge_sense u_edge (
                .ref_clk (ref_clk),
                .rst_n   (rst_n),
                .ce      (ce),
                .tick    (tick),
                .pin     (count_pins[gi]),
                .fall    (edge_fall[gi])
            );

            assign src = cfg_q[gi].cnt_sel ? edge_fall[gi] : tick;
            // timer 1 keeps running without its own run bit while timer 0 is in split mode, unless timer 1 is itself in reload or split mode
            assign run_eff = (gi == 0) ? run_q[0] : (split0 | run_q[1]);
            assign allowed = (gi == 0) ? 1'b1 : ~cfg_q[1].mode[1];
            assign inc[gi] = ce & run_eff & allowed & src
                           & (~cfg_q[gi].gate | gate_pins[gi]);
            assign step[gi]    = step_count(cfg_q[gi].mode, cnt_q[gi]);
            assign ovf_evt[gi] = inc[gi] & step[gi].ovf;

            always_comb begin
                cnt_d[gi] = cnt_q[gi];
                if (inc[gi]) begin
                    cnt_d[gi] = step[gi].cnt;
                end
                if ((gi == 0) && hi_inc) begin
                    cnt_d[gi].high = cnt_q[gi].high + 8'h01;
                end
                if (wr_lo[gi]) begin
                    cnt_d[gi].low = pwdata[7:0];
                end
                if (wr_hi[gi]) begin
                    cnt_d[gi].high = pwdata[7:0];
                end
            end

            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    cnt_q[gi] <= {RST_BYTE, RST_BYTE};
                end else if (ce) begin
                    cnt_q[gi] <= cnt_d[gi];
                end
            end
        end
    endgenerate

    // split high byte counts machine cycles under timer 1's run bit
    assign hi_inc = ce & tick & run_q[1] & split0;
    assign hi_ovf = hi_inc & (cnt_q[0].high == BYTE_MAX);

    // ------------------------------------------------------------------
    // overflow flags and serial port pulse
    // ------------------------------------------------------------------
    assign flag_set[0] = ovf_evt[0];
    assign flag_set[1] = split0 ? hi_ovf : ovf_evt[1];
    assign flag_clr[0] = vec_ack[0]
                       | (wr_en & (paddr == ADDR_CTRL) & ~pwdata[CTRL_OVF0_BIT]);
    assign flag_clr[1] = vec_ack[1]
                       | (wr_en & (paddr == ADDR_CTRL) & ~pwdata[CTRL_OVF1_BIT]);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ovf_flag_0 <= RST_FLAG[0];
            ovf_flag_1 <= RST_FLAG[1];
        end else if (ce) begin
            // a new overflow beats a clear in the same cycle
            ovf_flag_0 <= flag_set[0] | (ovf_flag_0 & ~flag_clr[0]);
            ovf_flag_1 <= flag_set[1] | (ovf_flag_1 & ~flag_clr[1]);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            baud_pulse <= 1'b0;
        end else if (ce) begin
            baud_pulse <= ovf_evt[1];
        end
    end

    // ------------------------------------------------------------------
    // mode and run control, committed at instruction end
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cfg_pend_q <= RST_MODE;
            run_pend_q <= RST_RUN;
        end else if (ce) begin
            if (wr_en && (paddr == ADDR_MODE)) begin
                cfg_pend_q <= pwdata[7:0];
            end
            if (wr_en && (paddr == ADDR_CTRL)) begin
                run_pend_q <= {pwdata[CTRL_RUN1_BIT], pwdata[CTRL_RUN0_BIT]};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cfg_q <= RST_MODE;
            run_q <= RST_RUN;
        end else if (ce && instr_done) begin
            // counts are not touched when run is committed
            cfg_q <= cfg_pend_q;
            run_q <= run_pend_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fast_q <= 1'b0;
        end else if (ce && wr_en && (paddr == ADDR_CLK)) begin
            fast_q <= pwdata[CLK_FAST_BIT];
        end
    end

    // ------------------------------------------------------------------
    // apb slave: one wait state, registered answer
    // ------------------------------------------------------------------
    assign mapped = (paddr == ADDR_MODE) | (paddr == ADDR_CTRL) | (paddr == ADDR_CLK)
                  | (paddr == ADDR_TL0) | (paddr == ADDR_TH0)
                  | (paddr == ADDR_TL1) | (paddr == ADDR_TH1);
    assign acc_first = psel & penable & ~pready;
    assign wr_en     = psel & penable & pready & pwrite & mapped;
    assign wr_lo     = {wr_en & (paddr == ADDR_TL1), wr_en & (paddr == ADDR_TL0)};
    assign wr_hi     = {wr_en & (paddr == ADDR_TH1), wr_en & (paddr == ADDR_TH0)};

    always_comb begin
        rd_byte = 8'h00;
        unique case (1'b1)
            (paddr == ADDR_MODE): rd_byte = cfg_q;
            (paddr == ADDR_CTRL): rd_byte = {ovf_flag_1, run_q[1], ovf_flag_0, run_q[0],
                                             4'h0};
            (paddr == ADDR_TL0):  rd_byte = cnt_q[0].low;
            (paddr == ADDR_TH0):  rd_byte = cnt_q[0].high;
            (paddr == ADDR_TL1):  rd_byte = cnt_q[1].low;
            (paddr == ADDR_TH1):  rd_byte = cnt_q[1].high;
            (paddr == ADDR_CLK):  rd_byte = {7'h00, fast_q};
            default:              rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            pready  <= acc_first;
            pslverr <= acc_first & ~mapped;
            if (acc_first) begin
                prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // a switch to the short cycle may legally bring the next tick early
    tick_space_a: assert property (ce && tick && !fast_q
            |=> (!tick [*8]) or (##[0:7] fast_q))
        else $error("machine cycle shorter than twelve clocks");

    edge_rate_a: assert property (edge_fall[0] |=> !edge_fall[0] [*8])
        else $error("count pin edges recognised too close together");

    count_inc_a: assert property (ce && inc[0] && cfg_q[0].cnt_sel
            && cfg_q[0].mode == MODE_16 && !wr_lo[0] && !wr_hi[0] && !step[0].ovf
            |=> cnt_q[0] == $past(cnt_q[0]) + 16'h0001)
        else $error("counter did not advance on a recognised edge");

    gate_hold_a: assert property (ce && cfg_q[0].gate && !ext_irq_pin_0 && !split0
            && !wr_lo[0] && !wr_hi[0] |=> $stable(cnt_q[0]))
        else $error("gated timer counted while irq pin low");

    run_keep_a: assert property (ce && instr_done && run_pend_q[0] && !run_q[0]
            && !wr_lo[0] && !wr_hi[0] |=> $stable(cnt_q[0]))
        else $error("setting run altered the count");

    pend_hold_a: assert property (!instr_done |=> $stable(cfg_q) && $stable(run_q))
        else $error("control changed before instruction end");

    ovf_set_a: assert property (ce && ovf_evt[0] |=> ovf_flag_0 && ovf_flag_0 != 1'b0)
        else $error("overflow did not set the flag");

    reload_a: assert property (ce && ovf_evt[0] && cfg_q[0].mode == MODE_RELOAD
            && !wr_lo[0] && !wr_hi[0]
            |=> cnt_q[0].low == $past(cnt_q[0].high) && $stable(cnt_q[0].high))
        else $error("reload mode did not refill low byte from high byte");

    prescale_a: assert property (ce && inc[0] && cfg_q[0].mode == MODE_13
            && cnt_q[0].low[4:0] != PRESC_MAX && !wr_hi[0] |=> $stable(cnt_q[0].high))
        else $error("high byte moved before prescaler wrapped");

    t1_stop_a: assert property (cfg_q[1].mode[1] && !wr_lo[1] && !wr_hi[1]
            |=> $stable(cnt_q[1]))
        else $error("timer 1 counted in a stopped mode");

    split_hi_a: assert property (hi_inc && !wr_hi[0]
            |=> cnt_q[0].high == $past(cnt_q[0].high) + 8'h01)
        else $error("split high byte did not count the machine cycle");

    baud_a: assert property (ce && ovf_evt[1] |=> baud_pulse ##1 (!baud_pulse || !ce))
        else $error("timer 1 overflow gave no single serial pulse");

    ack_clr_a: assert property (ce && vec_ack[0] && !flag_set[0] |=> !ovf_flag_0)
        else $error("vectoring did not clear the overflow flag");

endmodule

/* File: tb/dtc_pin_model.sv */
// Purpose: far-side model of the count and gate pins
// Assumes: pins are synchronous to ref_clk
// Notes:   levels only change just after a rising edge
`timescale 1ns/100ps
module dtc_pin_model (
    input  wire logic ref_clk,
    output logic      count_input_0,
    output logic      count_input_1,
    output logic      ext_irq_pin_0,
    output logic      ext_irq_pin_1
);
    initial begin
        count_input_0 = 1'b1;
        count_input_1 = 1'b1;
        ext_irq_pin_0 = 1'b1;
        ext_irq_pin_1 = 1'b1;
    end

    // ----
    // stimulus tasks
    // ----
    // each level stands hold clocks so every level is sampled at least once
    task automatic pulse(input int n, input int hold);
        for (int i = 0; i < 2 * n; i++) begin
            @(posedge ref_clk);
            count_input_0 <= ~count_input_0;
            repeat (hold - 1) @(posedge ref_clk);
        end
    endtask

    task automatic gate(input logic g);
        @(posedge ref_clk);
        ext_irq_pin_0 <= g;
    endtask
endmodule

/* File: tb/dual_timer_counter_bench.sv */
// Purpose: self-checking bench for the dual timer/counter
// Assumes: ce tied high, apb master per handshake
// Notes:   expectations come from tick counts at 12 or 6 clocks
`timescale 1ns/100ps
module dual_timer_counter_bench;
    import dtc_pkg::*;
    logic        ref_clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        count_input_0;
    logic        count_input_1;
    logic        ext_irq_pin_0;
    logic        ext_irq_pin_1;
    logic        instr_done;
    logic [1:0]  vec_ack;
    logic        ovf_flag_0;
    logic        ovf_flag_1;
    logic        baud_pulse;
    logic [2:0]  obs;
    logic [31:0] rd;
    logic        se;
    int          err_count;
    int          comparisons;
    int          c;
    int          n;
    int          m;

    assign obs = {baud_pulse, ovf_flag_1, ovf_flag_0};

    dtc_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_input_0(count_input_0), .count_input_1(count_input_1),
        .ext_irq_pin_0(ext_irq_pin_0), .ext_irq_pin_1(ext_irq_pin_1),
        .instr_done(instr_done), .vec_ack(vec_ack), .ovf_flag_0(ovf_flag_0),
        .ovf_flag_1(ovf_flag_1), .baud_pulse(baud_pulse));

    dtc_pin_model pins (.ref_clk(ref_clk), .count_input_0(count_input_0),
        .count_input_1(count_input_1), .ext_irq_pin_0(ext_irq_pin_0),
        .ext_irq_pin_1(ext_irq_pin_1));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ----
    // shared tasks
    // ----
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic timed_out;
        err_count++;
        wrap_up;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) timed_out;
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // mode and run writes only land on an instruction boundary
    task automatic commit;
        @(posedge ref_clk);
        instr_done <= 1'b1;
        @(posedge ref_clk);
        instr_done <= 1'b0;
    endtask

    task automatic wait_rise(input int i, output int k);
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (obs[i] !== 1'b1 && k < 2000);
        if (k >= 2000) timed_out;
    endtask

    // ----
    // main sequence
    // ----
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        instr_done = 1'b0;
        vec_ack = 2'b00;
        err_count = 0;
        comparisons = 0;
        void'($urandom(32'he965c07f));
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 28; a += 4) rdc(8'(a), 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        chk({31'h0, se}, 32'h1);
        $display("test reset done");

        for (int f = 0; f < 2; f++) begin
            m = $urandom_range(3);
            n = (m + 1) * (f ? 6 : 12);
            apb(1'b1, ADDR_CLK, 32'(f));
            apb(1'b1, ADDR_TH0, 32'(255 - m));
            apb(1'b1, ADDR_TL0, 32'(255 - m));
            apb(1'b1, ADDR_MODE, 32'h0000_0002);
            apb(1'b1, ADDR_CTRL, 32'h0000_0010);
            commit;
            wait_rise(0, c);
            @(posedge ref_clk);
            vec_ack <= 2'b01;
            @(posedge ref_clk);
            vec_ack <= 2'b00;
            wait_rise(0, c);
            chk(32'(c + 2), 32'(n));
            rdc(ADDR_TH0, 32'(255 - m));
            apb(1'b1, ADDR_CTRL, 32'h0);
            commit;
            // an overflow before the stop lands may have set the flag again
            apb(1'b1, ADDR_CTRL, 32'h0);
        end
        apb(1'b1, ADDR_CLK, 32'h0);
        $display("test reload done");

        apb(1'b1, ADDR_TL1, 32'h0000_00FE);
        apb(1'b1, ADDR_TH1, 32'h0000_00FF);
        apb(1'b1, ADDR_MODE, 32'h0);
        // timer 0 runs alongside in 13-bit mode to exercise the prescaler
        apb(1'b1, ADDR_CTRL, 32'h0000_0050);
        commit;
        wait_rise(2, c);
        @(posedge ref_clk);
        chk({30'h0, baud_pulse, ovf_flag_1}, 32'h1);
        rdc(ADDR_TH1, 32'h0);
        apb(1'b0, ADDR_TL1, 32'h0);
        chk(rd & 32'h0000_00E0, 32'h0000_00E0);
        apb(1'b1, ADDR_CTRL, 32'h0000_0040);
        for (int k = 2; k < 4; k++) begin
            apb(1'b1, ADDR_MODE, 32'(k << 4));
            commit;
            apb(1'b0, ADDR_TL1, 32'h0);
            n = int'(rd);
            repeat (40) @(posedge ref_clk);
            rdc(ADDR_TL1, 32'(n));
        end
        $display("test timer1 done");

        apb(1'b1, ADDR_MODE, 32'h0000_0033);
        apb(1'b1, ADDR_TL0, 32'h0);
        apb(1'b1, ADDR_TH0, 32'h0000_00FF);
        apb(1'b1, ADDR_CTRL, 32'h0000_0040);
        commit;
        wait_rise(1, c);
        chk(32'(c >= 2 && c <= 13), 32'h1);
        rdc(ADDR_TL0, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h0);
        commit;
        $display("test split done");

        apb(1'b1, ADDR_MODE, 32'h0000_0009);
        apb(1'b1, ADDR_TL0, 32'h0000_0050);
        apb(1'b1, ADDR_TH0, 32'h0);
        pins.gate(1'b0);
        apb(1'b1, ADDR_CTRL, 32'h0000_0010);
        commit;
        repeat (40) @(posedge ref_clk);
        rdc(ADDR_TL0, 32'h0000_0050);
        pins.gate(1'b1);
        repeat (48) @(posedge ref_clk);
        apb(1'b0, ADDR_TL0, 32'h0);
        chk(32'(rd >= 32'h53 && rd <= 32'h55), 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h0);
        rdc(ADDR_CTRL, 32'h0000_0010);
        commit;
        rdc(ADDR_CTRL, 32'h0);
        $display("test gate done");

        apb(1'b1, ADDR_MODE, 32'h0000_0005);
        apb(1'b1, ADDR_TL0, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h0000_0010);
        commit;
        m = $urandom_range(8, 1);
        pins.pulse(m, 13);
        repeat (30) @(posedge ref_clk);
        rdc(ADDR_TL0, 32'(m));
        $display("test counter done");
        wrap_up;
    end
endmodule
